// File: adsp_params.svh
`ifndef ADSP_PARAMS_SVH
`define ADSP_PARAMS_SVH
// ==========================================
// timing
`define ADSP_CONV_CYCLES 4'd14
`define ADSP_INT_DIV 4'd4
// ==========================================
// widths and reset values
`define ADSP_DATA_W 12
`define ADSP_CH_N 4
`define ADSP_MASK_RESET 4'hf
`define ADSP_FIFO_DEPTH 16
`endif

// File: adsp_pkg.sv
package adsp_pkg;
    // conversion sequencer states, gray along idle -> conv -> done
    typedef enum logic [1:0] {
        ADSP_IDLE = 2'b00,
        ADSP_CONV = 2'b01,
        ADSP_DONE = 2'b11
    } adsp_state_t;
    // one result word with its channel
    typedef struct packed {
        logic [1:0] chan;
        logic [11:0] data;
    } adsp_word_t;
endpackage : adsp_pkg

// File: adsp_fifo.sv
`timescale 1ns/100ps
// ==========================================
// result fifo
module adsp_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // write side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // read side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];  // storage
    logic [AW:0] wp;  // write pointer with wrap bit
    logic [AW:0] rp;  // read pointer with wrap bit
    wire do_wr = in_valid && in_ready;
    wire do_rd = out_valid && out_ready;
    assign in_ready = (wp - rp) != (AW+1)'(DEPTH);
    assign out_valid = wp != rp;
    assign out_data = mem[rp[AW-1:0]];
    // pointers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp <= '0;
            rp <= '0;
        end else begin
            if (do_wr) wp <= wp + 1'b1;
            if (do_rd) rp <= rp + 1'b1;
        end
    end
    // storage write, no reset needed
    always_ff @(posedge clk) begin
        if (do_wr) mem[wp[AW-1:0]] <= in_data;
    end
endmodule : adsp_fifo

// File: adsp_core.sv
`timescale 1ns/100ps
`include "adsp_params.svh"
// Summary of operation
// - sequence from pins or mask register
// - standby_n low halts conversion activity
// - master clock internal or external select
// - each conversion takes fourteen master clocks
// - bit 11 is result msb
// - parameter picks twos complement or binary
// - low nibble bidirectional, upper output only
// - mask bit n enables channel n+1
// - end pulse low after every conversion
// - conv_start rise latches selection, starts
// - busy high until all selected channels done
// - write rise with cs low loads mask
// - outputs enabled only with rd, cs low
module adsp_core #(
    parameter bit BIPOLAR = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control pins
    input wire logic conv_start,
    input wire logic sequence_source_select,
    input wire logic [3:0] hw_channel_pins,
    input wire logic standby_n,
    input wire logic clock_source_select,
    input wire logic ext_conv_clock,
    // host strobes
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    // analog front-end sample, straight binary from the converter array
    input wire logic [11:0] sar_code,
    // data bus
    output logic [5:0] result_bus_high,
    output logic [1:0] result_bus_mid,
    input wire logic [3:0] result_bus_low_bidir_in,
    output logic [3:0] result_bus_low_bidir_out,
    output logic [3:0] result_bus_low_bidir_oe,
    output logic data_oe,
    // status
    output logic busy,
    output logic eoc_n,
    output logic standby_active
);
    // ==========================================
    // pin history and edges
    logic conv_d, wr_d, ext_d;
    logic [3:0] channel_enable_mask;
    logic [3:0] seq_mask;  // latched selection for this sequence
    logic [3:0] int_div;
    logic [3:0] cyc;  // master clocks within a conversion
    logic [1:0] chan;
    adsp_pkg::adsp_state_t state, next_state;
    wire conv_rise = conv_start && !conv_d;
    wire wr_rise = wr_n && !wr_d;
    wire ext_rise = ext_conv_clock && !ext_d;
    wire int_tick = int_div == `ADSP_INT_DIV - 4'd1;
    // external clock duty is the system's duty; edges only are used
    wire mclk_en = clock_source_select ? ext_rise : int_tick;
    wire [3:0] sel_src = sequence_source_select ? channel_enable_mask : hw_channel_pins;
    wire chan_on = seq_mask[chan];
    wire conv_last = mclk_en && cyc == `ADSP_CONV_CYCLES - 4'd1;
    wire [3:0] later = seq_mask & ~((4'd2 << chan) - 4'd1);
    wire more = |later;
    wire read_en = !cs_n && !rd_n;
    // pop the head only once the read has ended, so the word stands for the whole read
    wire rd_done = data_oe && !read_en;
    // ==========================================
    // result coding and fifo
    wire [11:0] coded = BIPOLAR ? {~sar_code[11], sar_code[10:0]} : sar_code;
    adsp_pkg::adsp_word_t wr_word, rd_word;
    logic fifo_valid, fifo_in_ready;
    assign wr_word = '{chan: chan, data: coded};
    wire push = state == adsp_pkg::ADSP_CONV && chan_on && conv_last;
    adsp_fifo #(.WIDTH(14), .DEPTH(`ADSP_FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_data(wr_word),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .out_data(rd_word),
        .out_valid(fifo_valid),
        .out_ready(rd_done)
    );
    // ==========================================
    // sequencer next state
    always_comb begin
        next_state = state;
        case (state)
            adsp_pkg::ADSP_IDLE: begin
                if (conv_rise && standby_n && |sel_src) next_state = adsp_pkg::ADSP_CONV;
            end
            adsp_pkg::ADSP_CONV: begin
                if (!standby_n) next_state = adsp_pkg::ADSP_IDLE;
                else if (conv_last && !more) next_state = adsp_pkg::ADSP_DONE;
            end
            adsp_pkg::ADSP_DONE: next_state = adsp_pkg::ADSP_IDLE;
            default: next_state = adsp_pkg::ADSP_IDLE;
        endcase
    end
    // ==========================================
    // edge history and divider
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conv_d <= 1'b0;
            wr_d <= 1'b1;
            ext_d <= 1'b0;
            int_div <= 4'h0;
        end else begin
            conv_d <= conv_start;
            wr_d <= wr_n;
            ext_d <= ext_conv_clock;
            int_div <= (int_tick || !standby_n) ? 4'h0 : int_div + 4'h1;
        end
    end
    // mask register, write on rising strobe with cs low and rd high
    always_ff @(posedge clk or posedge rst) begin
        if (rst) channel_enable_mask <= `ADSP_MASK_RESET;
        else if (wr_rise && !cs_n && rd_n) channel_enable_mask <= result_bus_low_bidir_in;
    end
    // sequence state, channel and cycle counters
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= adsp_pkg::ADSP_IDLE;
            seq_mask <= 4'h0;
            chan <= 2'd0;
            cyc <= 4'h0;
        end else begin
            state <= next_state;
            if (state == adsp_pkg::ADSP_IDLE && conv_rise) begin
                seq_mask <= sel_src;
                chan <= 2'd0;
                cyc <= 4'h0;
            end else if (state == adsp_pkg::ADSP_CONV && !chan_on) begin
                chan <= chan + 2'd1;  // skip unselected channel
            end else if (state == adsp_pkg::ADSP_CONV && mclk_en) begin
                cyc <= conv_last ? 4'h0 : cyc + 4'h1;
                if (conv_last) chan <= chan + 2'd1;
            end
        end
    end
    // status outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            eoc_n <= 1'b1;
            standby_active <= 1'b0;
        end else begin
            busy <= next_state == adsp_pkg::ADSP_CONV;
            eoc_n <= !push;
            standby_active <= !standby_n;
        end
    end
    // read port: output word registered, bus drives only during read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            result_bus_high <= 6'h00;
            result_bus_mid <= 2'h0;
            result_bus_low_bidir_out <= 4'h0;
            result_bus_low_bidir_oe <= 4'h0;
            data_oe <= 1'b0;
        end else begin
            result_bus_high <= rd_word.data[11:6];
            result_bus_mid <= rd_word.data[5:4];
            result_bus_low_bidir_out <= rd_word.data[3:0];
            result_bus_low_bidir_oe <= {4{read_en}};
            data_oe <= read_en;
        end
    end
    // ==========================================
    // checks
    // system clocks spent in the current conversion, counted apart from the sequencer
    logic [6:0] conv_clks;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) conv_clks <= 7'h00;
        else if (push || state != adsp_pkg::ADSP_CONV) conv_clks <= 7'h00;
        else conv_clks <= conv_clks + 7'h01;
    end
    a_busy_falls: assert property (@(posedge clk) disable iff (rst)
        (state == adsp_pkg::ADSP_CONV && conv_last && !more && standby_n) |=> ##1 !busy)
        else $error("busy did not fall after last conversion");
    a_eoc_pulse: assert property (@(posedge clk) disable iff (rst)
        push |=> !eoc_n ##1 eoc_n)
        else $error("end pulse not one cycle");
    // fourteen ticks of four clocks; the first one also carries divider phase and channel skips
    a_conv_len: assert property (@(posedge clk) disable iff (rst)
        (push && !clock_source_select) |-> (conv_clks >= 7'd52 && conv_clks <= 7'd58))
        else $error("conversion length wrong");
    a_mask_load: assert property (@(posedge clk) disable iff (rst)
        (wr_rise && !cs_n && rd_n) |=> channel_enable_mask == $past(result_bus_low_bidir_in))
        else $error("mask not loaded");
    a_bus_read: assert property (@(posedge clk) disable iff (rst)
        ##1 (data_oe == $past(!cs_n && !rd_n)))
        else $error("bus enable mismatch");
    a_low_oe: assert property (@(posedge clk) disable iff (rst)
        result_bus_low_bidir_oe == {4{data_oe}})
        else $error("low nibble enable mismatch");
    a_seq_latch: assert property (@(posedge clk) disable iff (rst)
        (state == adsp_pkg::ADSP_IDLE && conv_rise) |=> seq_mask == $past(sel_src))
        else $error("selection not latched");
    a_standby_stop: assert property (@(posedge clk) disable iff (rst)
        !standby_n |=> (state == adsp_pkg::ADSP_IDLE && !busy))
        else $error("standby did not stop");
    a_start_busy: assert property (@(posedge clk) disable iff (rst)
        (state == adsp_pkg::ADSP_IDLE && conv_rise && standby_n && |sel_src) |=> busy)
        else $error("busy not raised");
endmodule : adsp_core

// File: adsp_host_bus.sv
`timescale 1ns/100ps
// ==========================================
// host side of the shared low data nibble
module adsp_host_bus (
    // clock
    input wire logic clk,
    // host drive
    input wire logic host_oe,
    input wire logic [3:0] host_val,
    // device drive
    input wire logic [3:0] dev_oe,
    input wire logic [3:0] dev_out,
    // resolved wire
    output logic [3:0] bus
);
    logic [3:0] last; // level seen last cycle; these pins have no pull
    // device wins while reading, host while writing
    // undriven bits show the inverse of the last level, so a stale value never passes
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            bus[i] = dev_oe[i] ? dev_out[i] : (host_oe ? host_val[i] : ~last[i]);
        end
    end
    // remember the wire level
    always_ff @(posedge clk) begin
        last <= bus;
    end
endmodule : adsp_host_bus

// File: adc_sequence_parallel_port_tb.sv
`timescale 1ns/100ps
// ==========================================
// bench for the converter control and host port
module adc_sequence_parallel_port_tb;
    logic clk, rst, cs_n, rd_n, wr_n, conv_start, src_sel, standby_n_n, clk_sel, ext_clk, ext_en, host_oe;
    logic [3:0] pins, host_val, lo_out, lo_oe, lo_bus;
    logic [5:0] hi;
    logic [1:0] mid;
    logic [5:0] hi_b; // straight binary build, upper bits
    logic [1:0] mid_b;
    logic [3:0] lo_b;
    logic data_oe, busy, eoc_n, standby_n_act;
    int num_errors = 0;
    int checks_done = 0;
    int ec = 0; // divider for the external clock
    localparam logic [11:0] SAR = 12'h3a5; // converter code, held for every channel
    localparam logic [11:0] EXP = 12'hba5; // two's complement flips only the msb
    adsp_core uut (.clk(clk), .rst(rst), .conv_start(conv_start), .sequence_source_select(src_sel),
        .hw_channel_pins(pins), .standby_n(standby_n_n), .clock_source_select(clk_sel),
        .ext_conv_clock(ext_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .sar_code(SAR),
        .result_bus_high(hi), .result_bus_mid(mid), .result_bus_low_bidir_in(lo_bus),
        .result_bus_low_bidir_out(lo_out), .result_bus_low_bidir_oe(lo_oe), .data_oe(data_oe),
        .busy(busy), .eoc_n(eoc_n), .standby_active(standby_n_act));
    adsp_host_bus host (.clk(clk), .host_oe(host_oe), .host_val(host_val), .dev_oe(lo_oe),
        .dev_out(lo_out), .bus(lo_bus));
    // unipolar build on the same stimulus, shows plain binary
    adsp_core #(.BIPOLAR(1'b0)) uut_bin (.clk(clk), .rst(rst), .conv_start(conv_start),
        .sequence_source_select(src_sel), .hw_channel_pins(pins), .standby_n(standby_n_n),
        .clock_source_select(clk_sel), .ext_conv_clock(ext_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .sar_code(SAR), .result_bus_high(hi_b), .result_bus_mid(mid_b), .result_bus_low_bidir_in(lo_bus),
        .result_bus_low_bidir_out(lo_b), .result_bus_low_bidir_oe(), .data_oe(), .busy(), .eoc_n(),
        .standby_active());
    // ==========================================
    // clocks
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    // external clock at an even duty, period six system clocks
    always @(posedge clk) begin
        ec <= (ec == 2) ? 0 : ec + 1;
        if (ec == 2) ext_clk <= ext_en & ~ext_clk;
    end
    // ==========================================
    // helpers
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic chk(input logic [11:0] s, input logic [11:0] e);
        checks_done++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    // mask write: data held until after the write strobe rises
    task automatic wr(input logic [3:0] m);
        cs_n <= 0; wr_n <= 0; host_oe <= 1; host_val <= m;
        tick(2); wr_n <= 1;
        tick(2); cs_n <= 1; host_oe <= 0;
        tick(1);
    endtask : wr
    // one word read; bounded wait for the enable
    task automatic rd(input logic [11:0] e);
        int i;
        cs_n <= 0; rd_n <= 0;
        for (i = 0; i < 20; i++) begin
            tick(1); #1;
            if (data_oe === 1'b1) break;
        end
        chk(12'(i < 20), 12'h001);
        chk({hi, mid, lo_bus}, e);
        chk({hi_b, mid_b, lo_b}, SAR);
        chk(12'(lo_oe), 12'h00f);
        @(posedge clk); #1;
        chk({hi, mid, lo_bus}, e);
        @(posedge clk); rd_n <= 1; cs_n <= 1;
        tick(3); #1;
        chk(12'({data_oe, lo_oe}), 12'h000);
        tick(1);
    endtask : rd
    // start a sequence, count end pulses, time the first one
    task automatic run(input int n, input int lo, input int hi_b);
        int i, e, f;
        e = 0; f = 0;
        conv_start <= 1;
        for (i = 0; i < 3000; i++) begin
            tick(1); #1;
            if (i == 2) chk(12'(busy), 12'h001);
            if (eoc_n === 1'b0) begin
                e++;
                if (f == 0) f = i;
            end
            if (i > 3 && busy !== 1'b1) break;
        end
        chk(12'(i < 3000), 12'h001);
        chk(12'(e), 12'(n));
        chk(12'(f >= lo && f <= hi_b), 12'h001);
        @(posedge clk); conv_start <= 0;
        tick(2);
    endtask : run
    task automatic stop_test;
        $display("errors=%0d checks=%0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    // ==========================================
    // main sequence
    initial begin
        rst = 1; cs_n = 1; rd_n = 1; wr_n = 1; conv_start = 0; src_sel = 0; pins = 0;
        standby_n_n = 1; clk_sel = 0; ext_clk = 0; ext_en = 0; host_oe = 0; host_val = 0;
        tick(4); rst <= 0; #1;
        chk(12'({busy, ~eoc_n, data_oe}), 12'h000);
        tick(1);
        // mask picks channels one and three, pins ignored
        wr(4'h5); src_sel <= 1; pins <= 4'h8;
        tick(1); run(2, 50, 70);
        rd(EXP); rd(EXP);
        // pins pick channel four, external clock
        src_sel <= 0; clk_sel <= 1; ext_en <= 1;
        tick(1); run(1, 75, 100);
        rd(EXP);
        // standby in mid-conversion drops busy
        clk_sel <= 0; ext_en <= 0; conv_start <= 1;
        tick(10); standby_n_n <= 0;
        tick(4); #1;
        chk(12'({busy, standby_n_act}), 12'h001);
        @(posedge clk); standby_n_n <= 1; conv_start <= 0;
        tick(3);
        stop_test();
    end
endmodule : adc_sequence_parallel_port_tb
